// ==== rtl/stsem_evt_if.sv ====
// Interface: event flag set and clear strobes between top and flag bank
`timescale 1ns/1ps
`default_nettype none
interface stsem_evt_if;
    logic [2:0] set;
    logic [2:0] clr;
    logic [2:0] flags;
    modport ctrl (output set, output clr, input flags);
    modport bank (input set, input clr, output flags);
endinterface
`default_nettype wire

// ==== rtl/stsem_flags.sv ====
// Sticky event flag bank; a set wins over a clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module stsem_flags #(
    parameter int N = 3
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    stsem_evt_if.bank evt
);
    logic [N-1:0] flag_reg;
    logic [N-1:0] flag_next;
    always_comb begin
        flag_next = (flag_reg & ~evt.clr) | evt.set;
    end
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            flag_reg <= '0;
        end else begin
            flag_reg <= flag_next;
        end
    end
    assign evt.flags = flag_reg;
endmodule
`default_nettype wire

// ==== rtl/stsem_pkg.sv ====
// Package: register map, fields and encodings of the SPI target semaphore
// Contract
// - Semaphore-won flag, bit 0 at 0x128
// - Link bit makes transaction-done trigger take
// - Enable-set writes ones; reads show enables
// - Enable-clear writes ones; reads show enables
// - Owner field at 0x400: 0 free, 2 engine
// - Owner 1 means CPU; resets to CPU
// - Owner 3 engine holds, CPU take pending
// - Give task at 0x028 frees semaphore for engine
`default_nettype none
package stsem_pkg;
    localparam logic [11:0] TAKE_TASK_OFS = 12'h024;
    localparam logic [11:0] GIVE_TASK_OFS = 12'h028;
    localparam logic [11:0] DONE_FLAG_OFS = 12'h104;
    localparam logic [11:0] RXFULL_FLAG_OFS = 12'h110;
    localparam logic [11:0] WON_FLAG_OFS = 12'h128;
    localparam logic [11:0] LINKS_OFS = 12'h200;
    localparam logic [11:0] IRQ_SET_OFS = 12'h304;
    localparam logic [11:0] IRQ_CLR_OFS = 12'h308;
    localparam logic [11:0] OWNER_OFS = 12'h400;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_RXFULL_BIT = 1;
    localparam int IRQ_WON_BIT = 2;
    localparam int NUM_EVENTS = 3;
    localparam logic [2:0] IRQ_EN_RESET = 3'h0;
    localparam logic [1:0] OWNER_FREE = 2'h0;
    localparam logic [1:0] OWNER_CPU = 2'h1;
    localparam logic [1:0] OWNER_ENGINE = 2'h2;
    localparam logic [1:0] OWNER_HANDOVER = 2'h3;
    typedef enum logic [3:0] {
        ST_FREE = 4'h1,
        ST_CPU = 4'h2,
        ST_ENGINE = 4'h4,
        ST_HANDOVER = 4'h8
    } stsem_state_type;
endpackage
`default_nettype wire

// ==== rtl/stsem_top.sv ====
// Top: semaphore, event links, interrupt enables and Wishbone slave
`timescale 1ns/1ps
`default_nettype none
module stsem_top (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [11:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // Engine side
    input wire logic xfer_done_in,
    input wire logic rx_buffer_full_event_in,
    input wire logic engine_take_in,
    input wire logic engine_give_in,
    output logic engine_owns_out,
    output logic [1:0] semaphore_owner_out,
    // Interrupt
    output logic irq_out
);
    stsem_evt_if evt ();
    stsem_flags #(.N(stsem_pkg::NUM_EVENTS)) u_flags (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .evt(evt)
    );

    logic req;
    logic wr;
    logic [11:0] ofs;
    logic ack_reg;
    logic ack_next;
    logic [31:0] rdat_reg;
    logic [31:0] rdat_next;
    logic link_reg;
    logic link_next;
    logic [2:0] irq_en_reg;
    logic [2:0] irq_en_next;
    stsem_pkg::stsem_state_type st_reg;
    stsem_pkg::stsem_state_type st_next;
    logic take_task;
    logic give_task;
    logic cpu_take;
    logic won;
    logic [1:0] owner;

    // One-cycle answer; ack drops the cycle after it is given
    assign req = wb_cyc_in && wb_stb_in && !ack_reg;
    assign wr = req && wb_we_in && wb_sel_in[0];
    assign ofs = {wb_adr_in[11:2], 2'b00};
    assign take_task = wr && ofs == stsem_pkg::TAKE_TASK_OFS && wb_dat_in[0];
    assign give_task = wr && ofs == stsem_pkg::GIVE_TASK_OFS && wb_dat_in[0];
    assign cpu_take = take_task || (link_reg && xfer_done_in);

    // Semaphore ownership
    always_comb begin
        st_next = st_reg;
        won = 1'b0;
        unique case (st_reg)
            stsem_pkg::ST_FREE: begin
                if (cpu_take) begin
                    st_next = stsem_pkg::ST_CPU;
                    won = 1'b1;
                end else if (engine_take_in) begin
                    st_next = stsem_pkg::ST_ENGINE;
                end
            end
            stsem_pkg::ST_CPU: begin
                if (give_task) begin
                    st_next = stsem_pkg::ST_FREE;
                end
            end
            stsem_pkg::ST_ENGINE: begin
                if (cpu_take && engine_give_in) begin
                    st_next = stsem_pkg::ST_CPU;
                    won = 1'b1;
                end else if (cpu_take) begin
                    st_next = stsem_pkg::ST_HANDOVER;
                end else if (engine_give_in) begin
                    st_next = stsem_pkg::ST_FREE;
                end
            end
            stsem_pkg::ST_HANDOVER: begin
                if (engine_give_in) begin
                    st_next = stsem_pkg::ST_CPU;
                    won = 1'b1;
                end
            end
            default: st_next = stsem_pkg::ST_CPU;
        endcase
    end

    always_comb begin
        unique case (st_reg)
            stsem_pkg::ST_FREE: owner = stsem_pkg::OWNER_FREE;
            stsem_pkg::ST_CPU: owner = stsem_pkg::OWNER_CPU;
            stsem_pkg::ST_ENGINE: owner = stsem_pkg::OWNER_ENGINE;
            default: owner = stsem_pkg::OWNER_HANDOVER;
        endcase
    end

    // Event flags: hardware sets, software writes zero to clear
    always_comb begin
        evt.set = '0;
        evt.clr = '0;
        evt.set[stsem_pkg::IRQ_DONE_BIT] = xfer_done_in;
        evt.set[stsem_pkg::IRQ_RXFULL_BIT] = rx_buffer_full_event_in;
        evt.set[stsem_pkg::IRQ_WON_BIT] = won;
        if (wr && !wb_dat_in[0]) begin
            evt.clr[stsem_pkg::IRQ_DONE_BIT] =
                ofs == stsem_pkg::DONE_FLAG_OFS;
            evt.clr[stsem_pkg::IRQ_RXFULL_BIT] =
                ofs == stsem_pkg::RXFULL_FLAG_OFS;
            evt.clr[stsem_pkg::IRQ_WON_BIT] =
                ofs == stsem_pkg::WON_FLAG_OFS;
        end
    end

    // Configuration registers and read mux
    always_comb begin
        link_next = link_reg;
        irq_en_next = irq_en_reg;
        rdat_next = rdat_reg;
        ack_next = req;
        if (wr && ofs == stsem_pkg::LINKS_OFS) begin
            link_next = wb_dat_in[0];
        end
        if (wr && ofs == stsem_pkg::IRQ_SET_OFS) begin
            irq_en_next = irq_en_reg | wb_dat_in[2:0];
        end
        if (wr && ofs == stsem_pkg::IRQ_CLR_OFS) begin
            irq_en_next = irq_en_reg & ~wb_dat_in[2:0];
        end
        if (req) begin
            unique case (ofs)
                stsem_pkg::DONE_FLAG_OFS:
                    rdat_next = {31'h0, evt.flags[stsem_pkg::IRQ_DONE_BIT]};
                stsem_pkg::RXFULL_FLAG_OFS:
                    rdat_next = {31'h0, evt.flags[stsem_pkg::IRQ_RXFULL_BIT]};
                stsem_pkg::WON_FLAG_OFS:
                    rdat_next = {31'h0, evt.flags[stsem_pkg::IRQ_WON_BIT]};
                stsem_pkg::LINKS_OFS:
                    rdat_next = {31'h0, link_reg};
                stsem_pkg::IRQ_SET_OFS, stsem_pkg::IRQ_CLR_OFS:
                    rdat_next = {29'h0, irq_en_reg};
                stsem_pkg::OWNER_OFS:
                    rdat_next = {30'h0, owner};
                default:
                    rdat_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            st_reg <= stsem_pkg::ST_CPU;
            link_reg <= 1'b0;
            irq_en_reg <= stsem_pkg::IRQ_EN_RESET;
            rdat_reg <= 32'h0;
            ack_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            link_reg <= link_next;
            irq_en_reg <= irq_en_next;
            rdat_reg <= rdat_next;
            ack_reg <= ack_next;
        end
    end

    assign wb_ack_out = ack_reg;
    assign wb_dat_out = rdat_reg;
    assign semaphore_owner_out = owner;
    assign engine_owns_out = st_reg == stsem_pkg::ST_ENGINE ||
        st_reg == stsem_pkg::ST_HANDOVER;
    assign irq_out = |(evt.flags & irq_en_reg);
endmodule
`default_nettype wire

// ==== tb/stsem_engine.sv ====
// Partner model: serial target engine strobes
`timescale 1ns/1ps
`default_nettype none
module stsem_engine (
    // Clock and bench commands: done, rx full, take, give
    input wire logic sys_clk_in,
    input wire logic [3:0] cmd_in,
    input wire logic owns_in,
    // Strobes towards the block
    output logic xfer_done_out,
    output logic rx_full_out,
    output logic take_out,
    output logic give_out
);
    // A give without ownership is dropped, as the real engine would
    always_ff @(posedge sys_clk_in) begin
        xfer_done_out <= cmd_in[0];
        rx_full_out <= cmd_in[1];
        take_out <= cmd_in[2];
        give_out <= cmd_in[3] && owns_in;
    end
endmodule
`default_nettype wire

// ==== tb/stsem_sva.sv ====
// Checker: port-level properties of the semaphore block
`timescale 1ns/1ps
`default_nettype none
module stsem_sva (
    // Clock, reset, bus
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic wb_ack_out,
    // Engine and interrupt
    input wire logic xfer_done_in,
    input wire logic rx_buffer_full_event_in,
    input wire logic engine_take_in,
    input wire logic engine_give_in,
    input wire logic engine_owns_out,
    input wire logic [1:0] semaphore_owner_out,
    input wire logic irq_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    logic wr;
    assign wr = wb_cyc_in && wb_stb_in && wb_we_in;
    AST_ACK: assert property (
        wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out)
        else $error("ack not a one-cycle answer");
    AST_OWNS: assert property (
        engine_owns_out == semaphore_owner_out[1])
        else $error("engine ownership disagrees with owner code");
    AST_RST_CPU: assert property (
        $fell(rst_in) |-> semaphore_owner_out == 2'h1)
        else $error("owner after reset not cpu");
    AST_CPU_KEEP: assert property (
        semaphore_owner_out == 2'h1 && !wr |=> semaphore_owner_out == 2'h1)
        else $error("cpu lost semaphore without a write");
    AST_ENG_TAKE: assert property (
        semaphore_owner_out == 2'h0 && engine_take_in && !xfer_done_in
        && !wr |=> semaphore_owner_out == 2'h2)
        else $error("engine take from free ignored");
    AST_FREE_WAIT: assert property (
        semaphore_owner_out == 2'h0 && !engine_take_in |=>
        semaphore_owner_out != 2'h2)
        else $error("engine owns without a take");
    AST_ENG_GIVE: assert property (
        semaphore_owner_out == 2'h2 && engine_give_in && !wr
        && !xfer_done_in |=>
        semaphore_owner_out == 2'h0)
        else $error("engine give did not free");
    AST_HANDOVER: assert property (
        semaphore_owner_out == 2'h3 && engine_give_in |=>
        semaphore_owner_out == 2'h1)
        else $error("pending handover not passed to cpu");
    AST_IRQ_CAUSE: assert property (
        $rose(irq_out) |-> $past(xfer_done_in || rx_buffer_full_event_in
        || engine_give_in || wr))
        else $error("interrupt rose without a cause");
endmodule
bind stsem_top stsem_sva i_sva (.sys_clk_in, .rst_in, .wb_cyc_in,
    .wb_stb_in, .wb_we_in, .wb_ack_out, .xfer_done_in,
    .rx_buffer_full_event_in, .engine_take_in, .engine_give_in,
    .engine_owns_out, .semaphore_owner_out, .irq_out);
`default_nettype wire

// ==== tb/stsem_top_tb.sv ====
// Testbench: semaphore, links and interrupt enables over Wishbone
`timescale 1ns/1ps
`default_nettype none
module stsem_top_tb;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0] sel = 4'hf, cmd = 4'h0;
    logic [31:0] dat = 32'h0, rdat, q;
    logic ack, done, rxf, take, give, owns, irq;
    logic [1:0] owner;
    int n_fail = 0;
    int check_count = 0;
    always #5 clk = ~clk;
    stsem_top i_dut (.sys_clk_in(clk), .rst_in(rst), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
        .wb_dat_in(dat), .wb_dat_out(rdat), .wb_ack_out(ack),
        .xfer_done_in(done), .rx_buffer_full_event_in(rxf),
        .engine_take_in(take), .engine_give_in(give),
        .engine_owns_out(owns), .semaphore_owner_out(owner), .irq_out(irq));
    stsem_engine i_eng (.sys_clk_in(clk), .cmd_in(cmd), .owns_in(owns),
        .xfer_done_out(done), .rx_full_out(rxf), .take_out(take),
        .give_out(give));
    task automatic final_report;
        $display("Checks %0d errors %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            $display("Error at %0t got %h expected %h", $time, g, e);
            n_fail++;
        end
    endtask
    task automatic wb(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
        // Ack and read data are taken at the rising edge that sees ack high
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        if (n >= 20) n_fail++;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'hf);
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0, 4'hf);
        chk(q, e);
    endtask
    task automatic ci(input logic e);
        @(negedge clk);
        chk({31'h0, irq}, {31'h0, e});
    endtask
    // One pulse through the engine model, then let it land in the block
    task automatic ev(input logic [3:0] c);
        @(posedge clk) cmd <= c;
        @(posedge clk) cmd <= 4'h0;
        @(posedge clk);
    endtask
    task automatic t_reset;
        rc(12'h400, 32'h1);
        rc(12'h128, 32'h0);
        rc(12'h200, 32'h0);
        rc(12'h304, 32'h0);
        rc(12'h7fc, 32'h0);
    endtask
    task automatic t_enables;
        wr(12'h304, 32'h7);
        rc(12'h304, 32'h7);
        wr(12'h308, 32'h1);
        rc(12'h308, 32'h6);
        wb(1'b1, 12'h200, 32'h1, 4'he);
        rc(12'h200, 32'h0);
    endtask
    task automatic t_handover;
        wr(12'h028, 32'h1);
        rc(12'h400, 32'h0);
        ev(4'h4);
        rc(12'h400, 32'h2);
        wr(12'h024, 32'h1);
        rc(12'h400, 32'h3);
        ci(1'b0);
        ev(4'h8);
        rc(12'h400, 32'h1);
        rc(12'h128, 32'h1);
        ci(1'b1);
        wr(12'h128, 32'h0);
        rc(12'h128, 32'h0);
        ci(1'b0);
    endtask
    task automatic t_links;
        wr(12'h028, 32'h1);
        ev(4'h1);
        rc(12'h400, 32'h0);
        rc(12'h104, 32'h1);
        wr(12'h200, 32'h1);
        ev(4'h1);
        rc(12'h400, 32'h1);
        rc(12'h128, 32'h1);
        wr(12'h128, 32'h0);
        ev(4'h2);
        ci(1'b1);
        wr(12'h110, 32'h0);
        ci(1'b0);
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        final_report;
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_enables;
        t_handover;
        t_links;
        final_report;
    end
endmodule
`default_nettype wire
